// file: rtl/scg_consts.vh
`ifndef SCG_CONSTS_VH
`define SCG_CONSTS_VH

// Register byte offsets on the Avalon-MM slave.
`define SCG_ADDR_W 12
`define SCG_OFS_SLEEP_GATE 12'h110
`define SCG_OFS_IRQ_STATUS 12'h200
`define SCG_OFS_IRQ_CLEAR 12'h204
`define SCG_OFS_IRQ_ENABLE 12'h208
`define SCG_OFS_GATE_STATE 12'h20c

// Field positions of the sleep gating register.
`define SCG_BIT_PWM 20
`define SCG_BIT_HIBER 6
`define SCG_BIT_WDOG 3

// Reset value and writable mask of the sleep gating register.
`define SCG_GATE_RST 32'h00000040
`define SCG_GATE_WMASK 32'h00100048

// Unit index inside the three-bit unit vectors.
`define SCG_UNITS 3
`define SCG_UNIT_WDOG 0
`define SCG_UNIT_HIBER 1
`define SCG_UNIT_PWM 2
`define SCG_UNIT_RST 3'h2

// Field positions of the gate state register.
`define SCG_ST_AUTO 4
`define SCG_ST_MODE_LO 5
`define SCG_ST_MODE_HI 6

// Avalon-MM response codes.
`define SCG_RESP_OKAY 2'h0
`define SCG_RESP_DECODE 2'h3

`endif

// file: rtl/scg_clk_gate.v
`timescale 1ns/1ps

// Glitch-free clock gate for one unit: the enable is retimed on the falling
// edge, so it only changes while the clock is low and no pulse is shortened.
module scg_clk_gate #(
    parameter [0:0] RST_VAL = 1'b0
) (
    // Clock and reset.
    input wire core_clk_i,
    input wire rst_i,
    // Enable in, gated clock and applied enable out.
    input wire en_i,
    output wire gclk_o,
    output wire en_o
);

    reg en_low_ff;

    // Enable is captured while the clock is low, so the AND below never cuts a high phase.
    always @(negedge core_clk_i) begin
        if (rst_i) begin
            en_low_ff <= RST_VAL;
        end else begin
            en_low_ff <= en_i;
        end
    end

    // Gated clock and the enable actually applied to the unit.
    assign gclk_o = core_clk_i & en_low_ff;
    assign en_o = en_low_ff;

endmodule // scg_clk_gate

// file: rtl/scg_ctrl.v
`timescale 1ns/1ps
`include "scg_consts.vh"

module scg_ctrl (
    // Clock and synchronous reset.
    input wire core_clk_i,
    input wire rst_i,
    // Avalon-MM register slave.
    input wire [11:0] avs_address_i,
    input wire avs_read_i,
    input wire avs_write_i,
    input wire [31:0] avs_writedata_i,
    input wire [3:0] avs_byteenable_i,
    output wire [31:0] avs_readdata_o,
    output wire avs_waitrequest_o,
    output wire [1:0] avs_response_o,
    // Run and deep-sleep gating values and the power state from the system controller.
    input wire [2:0] run_gate_i,
    input wire [2:0] deep_sleep_gate_i,
    input wire auto_gating_select_i,
    input wire sleep_i,
    input wire deep_sleep_i,
    // Unit access attempts and the resulting bus fault.
    input wire [2:0] unit_access_i,
    output wire bus_fault_o,
    output wire [2:0] fault_unit_o,
    // Unit clocks and their applied enables.
    output wire [2:0] unit_clk_o,
    output wire [2:0] unit_clk_en_o,
    // Level interrupt.
    output wire irq_o
);

    // Operating modes used to pick the gating set.
    localparam [1:0] MODE_RUN = 2'h0;
    localparam [1:0] MODE_SLEEP = 2'h1;
    localparam [1:0] MODE_DEEP = 2'h2;

    // Places three unit bits at their register positions; every other bit reads zero.
    // Used both for readback and as the old word of a byte-lane merge.
    function [31:0] pack_units;
        input [2:0] u;
        begin
            pack_units = 32'h00000000;
            pack_units[`SCG_BIT_WDOG] = u[`SCG_UNIT_WDOG];
            pack_units[`SCG_BIT_HIBER] = u[`SCG_UNIT_HIBER];
            pack_units[`SCG_BIT_PWM] = u[`SCG_UNIT_PWM];
        end
    endfunction

    // Extracts the three unit bits from a register word.
    function [2:0] unpack_units;
        input [31:0] w;
        begin
            unpack_units = 3'h0;
            unpack_units[`SCG_UNIT_WDOG] = w[`SCG_BIT_WDOG];
            unpack_units[`SCG_UNIT_HIBER] = w[`SCG_BIT_HIBER];
            unpack_units[`SCG_UNIT_PWM] = w[`SCG_BIT_PWM];
        end
    endfunction

    // Merges write data into an old word under the byte enables.
    // Lanes whose enable is low keep their old contents, so partial writes are safe.
    function [31:0] merge_bytes;
        input [31:0] old;
        input [31:0] data;
        input [3:0] be;
        integer k;
        begin
            merge_bytes = old;
            for (k = 0; k < 4; k = k + 1) begin
                if (be[k]) begin
                    merge_bytes[8*k +: 8] = data[8*k +: 8];
                end
            end
        end
    endfunction

    // Register state.
    // Only the three enables are kept for the gating register; the bus word is rebuilt on read.
    reg [2:0] sleep_gate_ff;
    reg [2:0] irq_status_ff;
    reg [2:0] irq_enable_ff;
    reg ack_ff;
    reg [31:0] rdata_ff;
    reg [1:0] resp_ff;
    reg fault_ff;
    reg [2:0] fault_unit_ff;
    reg irq_ff;

    // Next values.
    // These are combinational; only the registers ending in _ff hold state.
    reg [2:0] nxt_sleep_gate;
    reg [2:0] nxt_irq_status;
    reg [2:0] nxt_irq_enable;
    reg [31:0] nxt_rdata;
    reg [1:0] nxt_resp;
    reg [1:0] mode;
    reg [2:0] want_en;

    // Bus decode.
    wire req;
    wire wr_go;
    wire hit_gate;
    wire hit_status;
    wire hit_clear;
    wire hit_enable;
    wire hit_state;
    wire mapped;
    wire [2:0] applied_en;
    wire [2:0] fault_now;
    wire [31:0] wmerged_gate;
    wire [31:0] wmerged_clear;
    wire [31:0] wmerged_enable;

    // A request waits one cycle, then completes with waitrequest low.
    // Waitrequest is combinational so it stands in the very cycle of the request; the registered
    // acknowledge then bounds every transfer to exactly one wait state.
    assign req = avs_read_i | avs_write_i;
    assign avs_waitrequest_o = req & ~ack_ff;
    assign wr_go = avs_write_i & ack_ff;

    // Address decode of the five registers.
    // Full compares, so aliases never answer and stray offsets give a decode error.
    assign hit_gate = (avs_address_i == `SCG_OFS_SLEEP_GATE);
    assign hit_status = (avs_address_i == `SCG_OFS_IRQ_STATUS);
    assign hit_clear = (avs_address_i == `SCG_OFS_IRQ_CLEAR);
    assign hit_enable = (avs_address_i == `SCG_OFS_IRQ_ENABLE);
    assign hit_state = (avs_address_i == `SCG_OFS_GATE_STATE);
    assign mapped = hit_gate | hit_status | hit_clear | hit_enable | hit_state;

    // Byte-lane merges for the writable registers.
    assign wmerged_gate = merge_bytes(pack_units(sleep_gate_ff), avs_writedata_i, avs_byteenable_i);
    assign wmerged_clear = merge_bytes(32'h00000000, avs_writedata_i, avs_byteenable_i);
    assign wmerged_enable = merge_bytes({29'h0, irq_enable_ff}, avs_writedata_i, avs_byteenable_i);

    // Mode selection: sleep sets are used only when auto gating is selected.
    // Deep sleep outranks sleep, since both may be raised while the system descends.
    always @* begin
        if (!auto_gating_select_i) begin
            mode = MODE_RUN;
        end else if (deep_sleep_i) begin
            mode = MODE_DEEP;
        end else if (sleep_i) begin
            mode = MODE_SLEEP;
        end else begin
            mode = MODE_RUN;
        end
    end

    // Gating set in force for the current mode.
    // Without auto gating the run set stays in force in every power state.
    always @* begin
        case (mode)
            MODE_RUN: begin
                want_en = run_gate_i;
            end
            MODE_SLEEP: begin
                want_en = sleep_gate_ff;
            end
            MODE_DEEP: begin
                want_en = deep_sleep_gate_i;
            end
            default: begin
                want_en = run_gate_i;
            end
        endcase
    end

    // One glitch-free gate per unit; the hibernation gate starts enabled.
    // Each gate retimes its enable on the falling edge, so the applied enable lags the
    // selected set by half a cycle and a unit never sees a shortened clock pulse.
    genvar gi;
    generate
        for (gi = 0; gi < `SCG_UNITS; gi = gi + 1) begin : g_gate
            scg_clk_gate #(
                .RST_VAL(gi == `SCG_UNIT_HIBER)
            ) u_gate (
                .core_clk_i(core_clk_i),
                .rst_i(rst_i),
                .en_i(want_en[gi]),
                .gclk_o(unit_clk_o[gi]),
                .en_o(applied_en[gi])
            );
        end
    endgenerate

    assign unit_clk_en_o = applied_en;

    // Accesses aimed at an unclocked unit.
    // The check uses the applied enable, which is what the unit really receives, not the
    // selected one that may still be on its way through the gate.
    assign fault_now = unit_access_i & ~applied_en;

    // Sleep gating register write; only the three enable bits are stored.
    // Reserved bits are never stored, so they always read zero whatever software writes.
    always @* begin
        nxt_sleep_gate = sleep_gate_ff;
        if (wr_go && hit_gate) begin
            nxt_sleep_gate = unpack_units(wmerged_gate & `SCG_GATE_WMASK);
        end
    end

    // Interrupt status: a new fault wins over a clear in the same cycle.
    // Losing a fault to a coincident clear would hide an access that really failed.
    always @* begin
        nxt_irq_status = irq_status_ff;
        if (wr_go && hit_clear) begin
            nxt_irq_status = irq_status_ff & ~wmerged_clear[2:0];
        end
        nxt_irq_status = nxt_irq_status | fault_now;
    end

    // Interrupt enable register write.
    always @* begin
        nxt_irq_enable = irq_enable_ff;
        if (wr_go && hit_enable) begin
            nxt_irq_enable = wmerged_enable[2:0];
        end
    end

    // Read mux; reserved and write-only registers read as zero.
    // The clear register is write-only, so a read of it falls through to zero.
    always @* begin
        nxt_rdata = 32'h00000000;
        if (hit_gate) begin
            nxt_rdata = pack_units(sleep_gate_ff);
        end else if (hit_status) begin
            nxt_rdata = {29'h0, irq_status_ff};
        end else if (hit_enable) begin
            nxt_rdata = {29'h0, irq_enable_ff};
        end else if (hit_state) begin
            nxt_rdata[2:0] = applied_en;
            nxt_rdata[`SCG_ST_AUTO] = auto_gating_select_i;
            nxt_rdata[`SCG_ST_MODE_HI:`SCG_ST_MODE_LO] = mode;
        end
        nxt_resp = mapped ? `SCG_RESP_OKAY : `SCG_RESP_DECODE;
    end

    // Bus handshake and read data registers.
    // Read data and response are captured on the wait cycle and then hold until the next
    // request, so the master may take them at the edge that ends the wait.
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            ack_ff <= 1'b0;
            rdata_ff <= 32'h00000000;
            resp_ff <= `SCG_RESP_OKAY;
        end else begin
            ack_ff <= req & ~ack_ff;
            if (req && !ack_ff) begin
                rdata_ff <= avs_read_i ? nxt_rdata : 32'h00000000;
                resp_ff <= nxt_resp;
            end
        end
    end

    // Control and status registers; the interrupt flop is fed from the next values,
    // so it comes from a register and still rises in the cycle the status bit is set.
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            sleep_gate_ff <= `SCG_UNIT_RST;
            irq_status_ff <= 3'h0;
            irq_enable_ff <= 3'h0;
            irq_ff <= 1'b0;
        end else begin
            sleep_gate_ff <= nxt_sleep_gate;
            irq_status_ff <= nxt_irq_status;
            irq_enable_ff <= nxt_irq_enable;
            irq_ff <= |(nxt_irq_status & nxt_irq_enable);
        end
    end

    // Bus fault pulse towards the bus fabric, one cycle after the access.
    // One pulse per faulting access cycle; the sticky status keeps the record.
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            fault_ff <= 1'b0;
            fault_unit_ff <= 3'h0;
        end else begin
            fault_ff <= |fault_now;
            fault_unit_ff <= fault_now;
        end
    end

    // Outputs.
    assign avs_readdata_o = rdata_ff;
    assign avs_response_o = resp_ff;
    assign bus_fault_o = fault_ff;
    assign fault_unit_o = fault_unit_ff;
    assign irq_o = irq_ff;

endmodule // scg_ctrl

// file: bench/scg_props.sv
`timescale 1ns/1ps
`include "scg_consts.vh"

module scg_props (
    // Clock and reset.
    input wire core_clk_i,
    input wire rst_i,
    // Register bus.
    input wire [11:0] avs_address_i,
    input wire avs_read_i,
    input wire avs_write_i,
    input wire [31:0] avs_readdata_o,
    input wire avs_waitrequest_o,
    input wire [1:0] avs_response_o,
    // Power state and gating.
    input wire [2:0] run_gate_i,
    input wire [2:0] deep_sleep_gate_i,
    input wire auto_gating_select_i,
    input wire sleep_i,
    input wire deep_sleep_i,
    input wire [2:0] unit_access_i,
    input wire bus_fault_o,
    input wire [2:0] fault_unit_o,
    input wire [2:0] unit_clk_o,
    input wire [2:0] unit_clk_en_o,
    input wire irq_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    // Helper terms for gated accesses and finished reads.
    wire [2:0] bad = unit_access_i & ~unit_clk_en_o;
    wire rd_done = avs_read_i && !avs_waitrequest_o;
    wire mapped = avs_address_i inside {`SCG_OFS_SLEEP_GATE, `SCG_OFS_IRQ_STATUS, `SCG_OFS_IRQ_CLEAR,
        `SCG_OFS_IRQ_ENABLE, `SCG_OFS_GATE_STATE};
    wire sleepy = sleep_i || deep_sleep_i;
    // A request waits one cycle and then completes.
    sequence s_req;
        (avs_read_i || avs_write_i) && avs_waitrequest_o;
    endsequence
    sequence s_ack;
        !avs_waitrequest_o;
    endsequence
    a_bus_one_wait: assert property (s_req |=> s_ack) else $error("request not answered in one cycle");
    a_fault_pulse: assert property (|bad |=> bus_fault_o && fault_unit_o == $past(bad))
        else $error("missing bus fault");
    a_no_fault: assert property (bad == 3'h0 |=> !bus_fault_o) else $error("spurious bus fault");
    a_run_values: assert property (!auto_gating_select_i || !sleepy |-> unit_clk_en_o == run_gate_i)
        else $error("run enables not applied");
    a_deep_values: assert property (auto_gating_select_i && deep_sleep_i |->
        unit_clk_en_o == deep_sleep_gate_i) else $error("deep sleep enables not applied");
    a_clk_low: assert property (unit_clk_o == 3'h0) else $error("unit clock high while clock low");
    a_clk_high: assert property (@(negedge core_clk_i) unit_clk_o == unit_clk_en_o)
        else $error("unit clock does not follow enable");
    a_irq_cause: assert property ($rose(irq_o) |-> bus_fault_o || $past(avs_write_i && !avs_waitrequest_o))
        else $error("interrupt without cause");
    a_decode_resp: assert property (rd_done |-> avs_response_o == (mapped ? `SCG_RESP_OKAY : `SCG_RESP_DECODE)
        && (mapped || avs_readdata_o == 32'h0)) else $error("wrong read response");
    a_reserved_zero: assert property (rd_done && avs_address_i == `SCG_OFS_SLEEP_GATE |->
        (avs_readdata_o & ~`SCG_GATE_WMASK) == 32'h0) else $error("reserved bits not zero");
endmodule // scg_props

bind scg_ctrl scg_props u_props (.*);

// file: bench/scg_units.sv
`timescale 1ns/1ps

module scg_units (
    // Gated unit clocks.
    input wire [2:0] unit_clk_i,
    // Edge counts, eight bits per unit.
    output wire [23:0] edges_o
);
    // A unit only advances while its clock runs; each unit keeps a counter of its own.
    for (genvar k = 0; k < 3; k++) begin : g_unit
        logic [7:0] cnt_ff = 8'h00;
        always @(posedge unit_clk_i[k]) begin
            cnt_ff <= cnt_ff + 8'h01;
        end
        assign edges_o[8*k+:8] = cnt_ff;
    end
endmodule // scg_units

// file: bench/tb.sv
`timescale 1ns/1ps
`include "scg_consts.vh"

module tb;
    logic core_clk_i = 1'h0, rst_i = 1'h1, avs_read_i = 1'h0, avs_write_i = 1'h0;
    logic [11:0] avs_address_i = 12'h0;
    logic [31:0] avs_writedata_i = 32'h0, rd, e0;
    logic [3:0] avs_byteenable_i = 4'hf;
    logic [2:0] run_gate_i = 3'h2, deep_sleep_gate_i = 3'h5, unit_access_i = 3'h0;
    logic auto_gating_select_i = 1'h0, sleep_i = 1'h0, deep_sleep_i = 1'h0;
    logic [1:0] rs;
    wire [31:0] avs_readdata_o;
    wire avs_waitrequest_o, bus_fault_o, irq_o;
    wire [1:0] avs_response_o;
    wire [2:0] fault_unit_o, unit_clk_o, unit_clk_en_o;
    wire [23:0] edges;
    int miscompares = 0, checks_done = 0;
    // Rows: written value, readback, enables applied in sleep.
    logic [31:0] wr_t [5] = '{32'hffffffff, 32'h0, 32'h00100000, 32'h40, 32'h8};
    logic [31:0] rb_t [5] = '{32'h00100048, 32'h0, 32'h00100000, 32'h40, 32'h8};
    logic [2:0] en_t [5] = '{3'h7, 3'h0, 3'h4, 3'h2, 3'h1};
    // Modes {auto, sleep, deep} and the enables they select.
    logic [2:0] md_t [4] = '{3'h6, 3'h4, 3'h5, 3'h3};
    logic [2:0] me_t [4] = '{3'h1, 3'h6, 3'h5, 3'h6};
    scg_ctrl DUT (.*);
    scg_units U (.unit_clk_i(unit_clk_o), .edges_o(edges));
    // The 125 MHz clock.
    always #4 core_clk_i = ~core_clk_i;
    // Prints the counts and the verdict.
    task complete_run;
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task cyc(input int k);
        repeat (k) @(posedge core_clk_i);
    endtask
    // One transfer, held until waitrequest is sampled low.
    task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk_i);
        avs_read_i <= !w;
        avs_write_i <= w;
        avs_address_i <= a;
        avs_writedata_i <= d;
        do begin
            @(posedge core_clk_i);
            n++;
        end while (avs_waitrequest_o !== 1'h0 && n < 50);
        rd = avs_readdata_o;
        rs = avs_response_o;
        avs_read_i <= 1'h0;
        avs_write_i <= 1'h0;
        if (avs_waitrequest_o !== 1'h0) begin
            miscompares++;
            complete_run();
        end
    endtask
    initial begin
        cyc(20);
        rst_i <= 1'h0;
        bus(1'h0, `SCG_OFS_SLEEP_GATE, 32'h0);
        chk("gate reset", `SCG_GATE_RST, rd);
        chk("run enables", 32'h2, 32'(unit_clk_en_o));
        $display("reset test done");
        auto_gating_select_i <= 1'h1;
        sleep_i <= 1'h1;
        foreach (wr_t[i]) begin
            bus(1'h1, `SCG_OFS_SLEEP_GATE, wr_t[i]);
            bus(1'h0, `SCG_OFS_SLEEP_GATE, 32'h0);
            chk("gate readback", rb_t[i], rd);
            cyc(2);
            chk("sleep enables", 32'(en_t[i]), 32'(unit_clk_en_o));
            $display("row %0d done", i);
        end
        run_gate_i <= 3'h6;
        foreach (md_t[i]) begin
            {auto_gating_select_i, sleep_i, deep_sleep_i} <= md_t[i];
            cyc(2);
            chk("mode enables", 32'(me_t[i]), 32'(unit_clk_en_o));
        end
        // Gate state readback in deep sleep: enables 5, auto bit, mode code 2.
        {auto_gating_select_i, sleep_i, deep_sleep_i} <= 3'h5;
        bus(1'h0, `SCG_OFS_GATE_STATE, 32'h0);
        chk("gate state", 32'h55, rd);
        $display("mode test done");
        // Faults on gated units, sticky status and interrupt.
        {auto_gating_select_i, sleep_i, deep_sleep_i} <= 3'h6;
        bus(1'h1, `SCG_OFS_IRQ_ENABLE, 32'h7);
        unit_access_i <= 3'h6;
        cyc(1);
        unit_access_i <= 3'h0;
        cyc(1);
        chk("fault", 32'h1, 32'(bus_fault_o));
        chk("fault unit", 32'h6, 32'(fault_unit_o));
        chk("irq set", 32'h1, 32'(irq_o));
        bus(1'h0, `SCG_OFS_IRQ_STATUS, 32'h0);
        chk("status", 32'h6, rd);
        bus(1'h1, `SCG_OFS_IRQ_CLEAR, 32'h6);
        cyc(1);
        chk("irq clear", 32'h0, 32'(irq_o));
        e0 = 32'(edges);
        cyc(4);
        chk("unit edges", {8'h0, e0[23:8], e0[7:0] + 8'h04}, 32'(edges));
        $display("fault test done");
        bus(1'h0, 12'h300, 32'h0);
        chk("decode resp", 32'h3, 32'(rs));
        chk("decode data", 32'h0, rd);
        $display("unmapped test done");
        rst_i <= 1'h1;
        cyc(3);
        rst_i <= 1'h0;
        bus(1'h0, `SCG_OFS_SLEEP_GATE, 32'h0);
        chk("gate rereset", `SCG_GATE_RST, rd);
        bus(1'h0, `SCG_OFS_IRQ_ENABLE, 32'h0);
        chk("enable rereset", 32'h0, rd);
        $display("second reset test done");
        complete_run();
    end
endmodule // tb
